/* hw/cbu_branch_unit.sv */
// Conditional relative branch unit: decode, test, and program counter update.
// Overview of operation
// - Carry-set and lower branches are taken only when carry is one.
// - Carry-clear and same-or-higher branches are taken only when carry is zero.
// - The minus branch is taken only when the negative flag is one.
// - The plus branch is taken only when the negative flag is zero.
// - The signed greater-or-equal branch is taken only when N xor V is zero.
// - The signed less-than branch is taken only when N xor V is one.
// - The half-carry-set branch is taken only when half-carry is one.
// - The half-carry-clear branch is taken only when half-carry is zero.
// - The T-set branch is taken only when the T flag is one.
// - The T-clear branch is taken only when the T flag is zero.
// - The overflow-set branch is taken only when overflow is one.
// - A taken branch loads the program counter with itself plus offset plus one.
// - A branch finishes in one cycle when not taken and two when taken.
// - No branch changes any status flag.
`timescale 1ns/1ps
module cbu_branch_unit
   import cbu_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic insn_valid,
   input wire logic [INSN_W-1:0] insn,
   input wire logic [SREG_W-1:0] sreg_in,
   output logic insn_ready,
   output logic [PC_W-1:0] pc,
   output logic redirect,
   output logic branch_taken,
   output logic branch_done,
   output logic [SREG_W-1:0] sreg_out,
   output logic sreg_we
);
   // ****************************************
   // State
   // ****************************************
   typedef enum {CBU_S_EXEC, CBU_S_SECOND} cbu_state_t;
   typedef struct packed {
      cbu_state_t state;
      logic [PC_W-1:0] pc;
      logic redirect;
      logic taken;
      logic done;
   } cbu_regs_t;
   cbu_regs_t r;
   cbu_regs_t next_r;
   logic is_branch;
   logic cond_true;
   logic [PC_W-1:0] ofs_ext;
   cbu_op_t op;

   cbu_cond_eval u_eval (
      .insn(insn),
      .sreg(sreg_in),
      .is_branch(is_branch),
      .cond_true(cond_true),
      .op(op)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.redirect = 1'b0;
      next_r.done = 1'b0;
      next_r.taken = 1'b0;
      ofs_ext = {{(PC_W-OFS_W){insn[OFS_LSB+OFS_W-1]}}, insn[OFS_LSB +: OFS_W]};
      case (r.state)
         CBU_S_EXEC: begin
            if (insn_valid && is_branch) begin
               if (cond_true) begin
                  // target is pc plus offset plus one.
                  next_r.pc = PC_W'(r.pc + ofs_ext + PC_STEP);
                  // taken branch spends a second cycle.
                  next_r.state = CBU_S_SECOND;
                  next_r.redirect = 1'b1;
                  next_r.taken = 1'b1;
               end else begin
                  next_r.pc = PC_W'(r.pc + PC_STEP);
                  next_r.done = 1'b1;
               end
            end else if (insn_valid) begin
               // Non-branch words belong to other units; only sequence the counter.
               next_r.pc = PC_W'(r.pc + PC_STEP);
            end
         end
         CBU_S_SECOND: begin
            next_r.state = CBU_S_EXEC;
            next_r.done = 1'b1;
            next_r.taken = 1'b1;
         end
         default: next_r.state = CBU_S_EXEC;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         r <= '{state: CBU_S_EXEC, pc: PC_RESET, redirect: 1'b0, taken: 1'b0, done: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // The second cycle of a taken branch stalls the fetch so no word is lost.
   assign insn_ready = (r.state == CBU_S_EXEC);
   assign pc = r.pc;
   assign redirect = r.redirect;
   assign branch_taken = r.taken;
   assign branch_done = r.done;
   assign sreg_out = sreg_in;
   assign sreg_we = 1'b0;
endmodule

/* hw/cbu_pkg.sv */
// Package with encodings, flag positions and timing counts for the branch unit.
package cbu_pkg;
   localparam int PC_W = 12;
   localparam int OFS_W = 7;
   localparam int INSN_W = 16;
   localparam int SREG_W = 8;
   // Status register flag positions.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   // Branch group encoding: 1111 0s kkkkkkk bbb, s=0 set, s=1 clear.
   localparam logic [5:0] BR_PREFIX = 6'h3C;
   localparam logic [5:0] BR_PREFIX_CLR = 6'h3D;
   localparam int SEL_LSB = 0;
   localparam int OFS_LSB = 3;
   localparam int PFX_LSB = 10;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [PC_W-1:0] PC_STEP = 12'h001;
   localparam int CYC_NOT_TAKEN = 1;
   localparam int CYC_TAKEN = 2;
   typedef enum logic [3:0] {
      CBU_NONE,
      CBU_CARRY_SET,
      CBU_CARRY_CLEAR,
      CBU_MINUS,
      CBU_PLUS,
      CBU_SIGNED_GE,
      CBU_SIGNED_LT,
      CBU_HALF_SET,
      CBU_HALF_CLEAR,
      CBU_TFLAG_SET,
      CBU_TFLAG_CLEAR,
      CBU_OVF_SET,
      CBU_OVF_CLEAR,
      CBU_ZERO_SET,
      CBU_ZERO_CLEAR,
      CBU_OTHER
   } cbu_op_t;
endpackage

/* hw/cbu_cond_eval.sv */
// Condition evaluator: decodes a branch word and tests the status flags.
`timescale 1ns/1ps
module cbu_cond_eval
   import cbu_pkg::*;
(
   input wire logic [INSN_W-1:0] insn,
   input wire logic [SREG_W-1:0] sreg,
   output logic is_branch,
   output logic cond_true,
   output cbu_op_t op
);
   logic [2:0] sel;
   logic clr;
   always_comb begin
      sel = insn[SEL_LSB +: 3];
      clr = (insn[PFX_LSB +: 6] == BR_PREFIX_CLR);
      is_branch = (insn[PFX_LSB +: 6] == BR_PREFIX) || clr;
      op = CBU_NONE;
      cond_true = 1'b0;
      if (is_branch) begin
         case (sel)
            3'h0: op = clr ? CBU_CARRY_CLEAR : CBU_CARRY_SET;
            3'h1: op = clr ? CBU_ZERO_CLEAR : CBU_ZERO_SET;
            3'h2: op = clr ? CBU_PLUS : CBU_MINUS;
            3'h3: op = clr ? CBU_OVF_CLEAR : CBU_OVF_SET;
            3'h4: op = clr ? CBU_SIGNED_GE : CBU_SIGNED_LT;
            3'h5: op = clr ? CBU_HALF_CLEAR : CBU_HALF_SET;
            3'h6: op = clr ? CBU_TFLAG_CLEAR : CBU_TFLAG_SET;
            default: op = CBU_OTHER;
         endcase
         // signed combination of N and V.
         // signed less-than on N xor V.
         if (sel == 3'h4) begin
            cond_true = (sreg[FLAG_N] ^ sreg[FLAG_V]) ^ clr;
         end else begin
            cond_true = sreg[sel] ^ clr;
         end
      end
   end
endmodule

/* sim/cbu_checker.sv */
// Port checker for the branch unit.
`timescale 1ns/1ps
module cbu_checker
   import cbu_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic insn_valid,
   input wire logic [INSN_W-1:0] insn,
   input wire logic [SREG_W-1:0] sreg_in,
   input wire logic insn_ready,
   input wire logic [PC_W-1:0] pc,
   input wire logic redirect,
   input wire logic branch_taken,
   input wire logic branch_done,
   input wire logic [SREG_W-1:0] sreg_out,
   input wire logic sreg_we
);
   // ****
   // Decode
   // ****
   logic f;
   logic acc;
   logic br;
   logic [PC_W-1:0] tgt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   assign f = insn[2:0] == 3'h4 ? sreg_in[FLAG_N] ^ sreg_in[FLAG_V] : sreg_in[insn[2:0]];
   assign acc = insn_valid && insn_ready;
   assign br = acc && insn[15:11] == 5'h1E && insn[2:0] != 3'h7;
   // The target is captured a cycle early so the check sees the old pc.
   always_ff @(posedge core_clk) begin
      tgt <= pc + {{5{insn[9]}}, insn[9:3]} + PC_STEP;
   end
   chk_flags_kept: assert property (sreg_out == sreg_in && !sreg_we)
      else $error("flags written");
   chk_taken_target: assert property (br && (f ^ insn[10]) |=>
      redirect && pc == tgt) else $error("bad target");
   chk_skip_step: assert property (br && !(f ^ insn[10]) |=>
      !redirect && branch_done && pc == $past(pc) + PC_STEP) else $error("bad skip");
   chk_two_cycles: assert property (redirect |->
      !insn_ready && branch_taken ##1 branch_done && branch_taken && insn_ready)
      else $error("bad taken timing");
   chk_one_redirect: assert property (redirect |=> !redirect)
      else $error("long redirect");
   chk_pc_holds: assert property (!acc |=> $stable(pc))
      else $error("pc moved");
   chk_other_word: assert property (acc && insn[15:11] != 5'h1E |=>
      !branch_done && pc == $past(pc) + PC_STEP) else $error("bad other word");
   chk_signed_test: assert property (br && insn[2:0] == 3'h4 |=>
      redirect == ($past(f) ^ $past(insn[10]))) else $error("bad signed test");
endmodule
bind cbu_branch_unit cbu_checker chk (.core_clk, .nrst, .insn_valid, .insn, .sreg_in,
   .insn_ready, .pc, .redirect, .branch_taken, .branch_done, .sreg_out, .sreg_we);

/* sim/cbu_branch_unit_bench.sv */
// Self-checking bench for the branch unit.
`timescale 1ns/1ps
module cbu_branch_unit_bench
   import cbu_pkg::*;
;
   // ****
   // Stimulus
   // ****
   logic core_clk = 0, nrst = 0, insn_valid = 0, insn_ready, redirect, branch_taken;
   logic branch_done, sreg_we;
   logic [INSN_W-1:0] insn = 16'h0000;
   logic [SREG_W-1:0] sreg_in = 8'h00, sreg_out;
   logic [PC_W-1:0] pc, ep = 12'h000;
   int fails = 0, check_count = 0, cyc = 0;
   // Row: taken, status flags, word. Offsets include both extremes, the negative -64 and the positive 63.
   logic [24:0] rows [16] = '{25'h101F028, 25'h000F018, 25'h100F7F0, 25'h001F408,
      25'h104F202, 25'h100F5FA, 25'h004F402, 25'h10CF414, 25'h104F024, 25'h008F414,
      25'h120F00D, 25'h020F40D, 25'h140F00E, 25'h100F40E, 25'h108F00B, 25'h0F7F00B};
   always #2.5 core_clk = ~core_clk;
   cbu_branch_unit uut (.core_clk, .nrst, .insn_valid, .insn, .sreg_in, .insn_ready, .pc,
      .redirect, .branch_taken, .branch_done, .sreg_out, .sreg_we);
   task automatic print_verdict();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(logic [PC_W-1:0] g, logic [PC_W-1:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_bit(logic g, logic e);
      cmp({11'h000, g}, {11'h000, e});
   endtask
   // Valid stays high, so the held word also probes refusal while not ready.
   task automatic run(logic [24:0] r);
      logic t;
      t = r[24];
      ep = ep + (t ? {{5{r[9]}}, r[9:3]} + PC_STEP : PC_STEP);
      insn = r[15:0];
      sreg_in = r[23:16];
      insn_valid = 1;
      @(posedge core_clk) #1;
      cmp(pc, ep);
      cmp_bit(redirect, t);
      cmp_bit(insn_ready, !t);
      cmp({4'h0, sreg_out}, {4'h0, r[23:16]});
      cmp_bit(sreg_we, 1'b0);
      cmp_bit(branch_taken, t);
      if (t) begin
         @(posedge core_clk) #1;
      end
      cmp_bit(branch_done, 1'b1);
      cmp_bit(branch_taken, t);
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 400) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      #1 nrst = 1;
      for (int i = 0; i < 16; i++) begin
         run(rows[i]);
         $display("row %0d done", i);
      end
      insn = 16'h0000;
      @(posedge core_clk) #1;
      ep = ep + PC_STEP;
      cmp(pc, ep);
      cmp_bit(branch_done, 1'b0);
      cmp_bit(redirect, 1'b0);
      insn_valid = 0;
      $display("other word done");
      nrst = 0;
      @(posedge core_clk) #1;
      cmp(pc, PC_RESET);
      cmp_bit(insn_ready, 1'b1);
      cmp_bit(branch_taken, 1'b0);
      $display("reset done");
      print_verdict();
   end
endmodule
